// ===== bench/hwmsc_chk.sv
// assertions on the special-config bank ports
module hwmsc_chk (
  input wire logic clk_sys, nrst, reg_wr, reg_rd, reg_hit, shared_pin_in, shared_pin_oe_n,
  input wire logic temp_over_limit, volt_over_limit, restart_pulse, digital_test_mode,
  input wire logic low_power_shutdown, cycle_monitor, offset_internal, test_value_active,
  input wire logic address_lsb, over_limit_alert,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, diode_avg_count, other_avg_count,
  input wire logic [7:0] test_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg_r;
  logic vsel_r;
  logic [2:0] up_r;
  // settle window covers the internal reset stretch
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) up_r <= 3'h0;
    else if (!up_r[2]) up_r <= up_r + 3'h1;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= 8'h00;
      vsel_r <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h4F) cfg_r <= reg_wdata & 8'h3F;
    else if (reg_wr && reg_addr == 8'h47) vsel_r <= reg_wdata[7];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_req(a, r);
    up_r[2] && r && reg_addr == a;
  endsequence
  a_test_store: assert property (
    s_req(8'h4C, reg_wr) |=> test_value == $past(reg_wdata)) else $error("test value lost");
  a_test_mirror: assert property (
    test_value_active == digital_test_mode) else $error("test mode not mirrored");
  a_mode_bits: assert property (
    up_r[2] |-> {offset_internal, cycle_monitor, low_power_shutdown} == {cfg_r[4], cfg_r[1:0]})
    else $error("mode outputs wrong");
  a_avg_count: assert property (
    up_r[2] |-> {diode_avg_count, other_avg_count} == (cfg_r[5] ? 16'h1001 : 16'h8008))
    else $error("averaging count wrong");
  a_reserved_zero: assert property (
    s_req(8'h4F, reg_rd) |=> reg_hit && reg_rdata == cfg_r) else $error("special readback");
  a_volt_alert: assert property (
    (up_r[2] && cfg_r[3] && volt_over_limit) [*4] |=> over_limit_alert) else $error("no alert");
  a_volt_quiet: assert property (
    (up_r[2] && !cfg_r[3] && !temp_over_limit) [*4] |=> !over_limit_alert)
    else $error("spurious alert");
  a_pin_alert: assert property (
    (up_r[2] && cfg_r[2] && temp_over_limit) [*4] |=> !shared_pin_oe_n) else $error("pin idle");
  a_pin_restart: assert property (
    (up_r[2] && !cfg_r[2] && vsel_r && restart_pulse) [*2] |=> !shared_pin_oe_n)
    else $error("restart not driven");
  a_pin_addr: assert property (
    (up_r[2] && !cfg_r[2] && !vsel_r && $stable(shared_pin_in)) [*4]
    |=> shared_pin_oe_n && address_lsb == $past(shared_pin_in)) else $error("address bit");
endmodule
bind hwmsc_top hwmsc_chk i_hwmsc_chk (.*);

// ===== bench/hwmsc_host_model.sv
// register-port host issuing single-byte accesses
module hwmsc_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  end
  // idle lines flip so a stale value never looks valid
  task automatic acc(input logic we, input logic [7:0] a, d);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {we, !we, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
  endtask
endmodule

// ===== bench/hwmsc_tb_top.sv
// self-checking bench for the special-config bank
module hwmsc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, diode_avg_count, other_avg_count, test_value;
  logic reg_wr, reg_rd, reg_hit, shared_pin_out, shared_pin_oe_n, low_power_shutdown;
  logic cycle_monitor, offset_internal, test_value_active, address_lsb, over_limit_alert;
  logic clk_sys = 0, nrst = 0, volt_over_limit = 0, temp_over_limit = 0, strap = 0;
  logic restart_pulse = 0, digital_test_mode = 0;
  wire shared_pin_in = shared_pin_oe_n & strap;
  int num_errors = 0, n_tests = 0;
  hwmsc_top i_hwmsc_top (.*);
  hwmsc_host_model i_hwmsc_host_model (.*);
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] diode_exp(input logic [7:0] d);
    return d[5] ? 8'd16 : 8'd128;
  endfunction
  task automatic wr(input logic [7:0] a, d);
    i_hwmsc_host_model.acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, exp, input logic hit);
    i_hwmsc_host_model.acc(1'b0, a, 8'h00);
    #1;
    chk(reg_rdata, exp);
    chk(8'(reg_hit), 8'(hit));
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    void'($urandom(32'hd1393007));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    step(4);
    chk(diode_avg_count, 8'd128);
    chk(other_avg_count, 8'd8);
    rdc(8'h4C, 8'h00, 1'b1);
    rdc(8'h4F, 8'h00, 1'b1);
    rdc(8'h50, 8'h00, 1'b0);
    for (int i = 0; i < 24; i++) begin
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      wr(8'h4C, ~d);
      digital_test_mode <= d[7];
      wr(8'h4F, d);
      rdc(8'h4F, d & 8'h3F, 1'b1);
      chk({low_power_shutdown, cycle_monitor, offset_internal}, {d[0], d[1], d[4]});
      chk(diode_avg_count, diode_exp(d));
      chk(other_avg_count, d[5] ? 8'd1 : 8'd8);
      rdc(8'h4C, ~d, 1'b1);
      chk(test_value, ~d);
      chk(8'(test_value_active), 8'(d[7]));
    end
    chk(8'(shared_pin_out), 8'h00);
    wr(8'h4F, 8'h04);
    temp_over_limit <= 1'b1;
    step(4);
    chk(shared_pin_oe_n, 1'b0);
    wr(8'h4F, 8'h08);
    {temp_over_limit, volt_over_limit} <= 2'b01;
    step(4);
    chk({over_limit_alert, shared_pin_oe_n}, 2'b11);
    wr(8'h4F, 8'h00);
    wr(8'h47, 8'h80);
    restart_pulse <= 1'b1;
    step(3);
    chk({over_limit_alert, shared_pin_oe_n}, 2'b00);
    rdc(8'h47, 8'h80, 1'b1);
    wr(8'h47, 8'h00);
    {restart_pulse, strap} <= 2'b01;
    step(5);
    chk(address_lsb, 1'b1);
    tally_and_finish();
  end
endmodule

// ===== inc/hwmsc_pkg.sv
// constants for the monitor special-configuration register bank
package hwmsc_pkg;
  localparam logic [7:0] ADDR_TEST_VALUE = 8'h4C;
  localparam logic [7:0] ADDR_SPECIAL = 8'h4F;
  localparam logic [7:0] ADDR_VOLT_ID = 8'h47;
  localparam logic [7:0] RESET_TEST_VALUE = 8'h00;
  localparam logic [7:0] RESET_SPECIAL = 8'h00;
  localparam logic [7:0] SPECIAL_WR_MASK = 8'h3F;
  localparam int BIT_SHUTDOWN = 0;
  localparam int BIT_CYCLE_MON = 1;
  localparam int BIT_ALERT_EN = 2;
  localparam int BIT_VOLT_ALERT = 3;
  localparam int BIT_OFS_INTERNAL = 4;
  localparam int BIT_LOW_AVG = 5;
  localparam int BIT_RESTART_SEL = 7;
  localparam logic [7:0] AVG_DIODE_FULL = 8'd128;
  localparam logic [7:0] AVG_OTHER_FULL = 8'd8;
  localparam logic [7:0] AVG_DIODE_LOW = 8'd16;
  localparam logic [7:0] AVG_OTHER_LOW = 8'd1;
  typedef enum logic [1:0] {
    HWMSC_PIN_ADDR = 2'b00,
    HWMSC_PIN_RESTART = 2'b01,
    HWMSC_PIN_ALERT = 2'b10
  } hwmsc_pin_t;
endpackage

// ===== logic/hwmsc_sync.sv
// two-flop synchroniser for pin-level inputs
module hwmsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== logic/hwmsc_top.sv
// special-function and test-value register bank of the hardware monitor
//
// Behaviour
// [RULE1] test-value register at 4C, reads/writes, resets zero, feeds digital test mode
// [RULE2] special bit 0: 0 sleep, 1 shutdown low-power state
// [RULE3] special bit 1: 0 continuous monitoring, 1 cycle monitoring
// [RULE4] bit 2 zero: pin is address/restart per voltage-ID bit 7; one: alert
// [RULE5] bit 3 one: voltage at or over limit drives alert low
// [RULE6] bit 4: 0 offset to external diodes, 1 to internal channel
// [RULE7] bit 5 zero: 128 diode samples, 8 for voltage and internal
// [RULE8] bit 5 one: 16 diode samples, voltage and internal unaveraged
// [RULE9] reserved bits 7:6 read-only zero
// [RULE10] voltage-ID bit 7: 0 address lsb pin, 1 restart output
module hwmsc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port from the serial slave logic
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // status from the monitor core
  input wire logic volt_over_limit,
  input wire logic temp_over_limit,
  input wire logic restart_pulse,
  input wire logic digital_test_mode,
  // shared pin, open drain style: oe low means driving
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_n,
  // configuration to the monitor core
  output logic low_power_shutdown,
  output logic cycle_monitor,
  output logic offset_internal,
  output logic [7:0] diode_avg_count,
  output logic [7:0] other_avg_count,
  output logic [7:0] test_value,
  output logic test_value_active,
  output logic address_lsb,
  output logic over_limit_alert
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flops
  logic [2:0] sync_q;
  hwmsc_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .d({shared_pin_in, temp_over_limit, volt_over_limit}),
    .q(sync_q)
  );
  logic pin_in_s;
  logic temp_s;
  logic volt_s;
  assign pin_in_s = sync_q[2];
  assign temp_s = sync_q[1];
  assign volt_s = sync_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] test_value_r;
  logic [7:0] special_r;
  logic restart_sel_r;
  logic wr_test;
  logic wr_special;
  logic wr_vid;
  assign wr_test = reg_wr && (reg_addr == hwmsc_pkg::ADDR_TEST_VALUE);
  assign wr_special = reg_wr && (reg_addr == hwmsc_pkg::ADDR_SPECIAL);
  assign wr_vid = reg_wr && (reg_addr == hwmsc_pkg::ADDR_VOLT_ID);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      test_value_r <= hwmsc_pkg::RESET_TEST_VALUE;
    end else if (wr_test) begin
      test_value_r <= reg_wdata; // RULE1
    end
  end

  // reserved bits never store, so they read zero
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      special_r <= hwmsc_pkg::RESET_SPECIAL;
    end else if (wr_special) begin
      special_r <= reg_wdata & hwmsc_pkg::SPECIAL_WR_MASK; // RULE9
    end
  end

  // only the pin-select bit of the voltage-ID register lives here
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      restart_sel_r <= 1'b0;
    end else if (wr_vid) begin
      restart_sel_r <= reg_wdata[hwmsc_pkg::BIT_RESTART_SEL]; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, registered
  logic [7:0] rdata_nxt;
  logic hit_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b1;
    if (reg_addr == hwmsc_pkg::ADDR_TEST_VALUE) begin
      rdata_nxt = test_value_r; // RULE1
    end else if (reg_addr == hwmsc_pkg::ADDR_SPECIAL) begin
      rdata_nxt = special_r & hwmsc_pkg::SPECIAL_WR_MASK; // RULE9
    end else if (reg_addr == hwmsc_pkg::ADDR_VOLT_ID) begin
      rdata_nxt = {restart_sel_r, 7'h00};
    end else begin
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
      reg_hit <= hit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs
  assign low_power_shutdown = special_r[hwmsc_pkg::BIT_SHUTDOWN]; // RULE2
  assign cycle_monitor = special_r[hwmsc_pkg::BIT_CYCLE_MON]; // RULE3
  assign offset_internal = special_r[hwmsc_pkg::BIT_OFS_INTERNAL]; // RULE6
  assign test_value = test_value_r;
  assign test_value_active = digital_test_mode; // RULE1

  // averaging depth handed to the conversion sequencer
  always_comb begin
    if (special_r[hwmsc_pkg::BIT_LOW_AVG]) begin
      diode_avg_count = hwmsc_pkg::AVG_DIODE_LOW; // RULE8
      other_avg_count = hwmsc_pkg::AVG_OTHER_LOW; // RULE8
    end else begin
      diode_avg_count = hwmsc_pkg::AVG_DIODE_FULL; // RULE7
      other_avg_count = hwmsc_pkg::AVG_OTHER_FULL; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pin function
  hwmsc_pkg::hwmsc_pin_t pin_mode;
  always_comb begin
    if (special_r[hwmsc_pkg::BIT_ALERT_EN]) begin
      pin_mode = hwmsc_pkg::HWMSC_PIN_ALERT; // RULE4
    end else if (restart_sel_r) begin
      pin_mode = hwmsc_pkg::HWMSC_PIN_RESTART; // RULE4
    end else begin
      pin_mode = hwmsc_pkg::HWMSC_PIN_ADDR; // RULE4
    end
  end

  logic alert_nxt;
  assign alert_nxt = temp_s || (special_r[hwmsc_pkg::BIT_VOLT_ALERT] && volt_s); // RULE5

  logic alert_r;
  logic drive_low_r;
  logic addr_r;
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      alert_r <= 1'b0;
      drive_low_r <= 1'b0;
    end else begin
      alert_r <= alert_nxt;
      case (pin_mode)
        hwmsc_pkg::HWMSC_PIN_ALERT: begin
          drive_low_r <= alert_nxt; // RULE5
        end
        hwmsc_pkg::HWMSC_PIN_RESTART: begin
          drive_low_r <= restart_pulse; // RULE4
        end
        default: begin
          drive_low_r <= 1'b0;
        end
      endcase
    end
  end

  // address bit sampled only while the pin is an input
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      addr_r <= 1'b0;
    end else if (pin_mode == hwmsc_pkg::HWMSC_PIN_ADDR) begin
      addr_r <= pin_in_s; // RULE4
    end
  end

  assign shared_pin_out = 1'b0;
  assign shared_pin_oe_n = ~drive_low_r;
  assign over_limit_alert = alert_r;
  assign address_lsb = addr_r;
endmodule
